// ### src/exs_pkg.sv
// Purpose: Constants for the exception state-save block
// Assumes: 32-bit APB, word-aligned registers
// Notes: Register indices are times four for byte addresses
package exs_pkg;
  // ********************
  // Register indices
  // ********************
  localparam logic [2:0] EXS_IDX_NPC = 3'h0;
  localparam logic [2:0] EXS_IDX_NPSW = 3'h1;
  localparam logic [2:0] EXS_IDX_FPC = 3'h2;
  localparam logic [2:0] EXS_IDX_FPSW = 3'h3;
  localparam logic [2:0] EXS_IDX_CAUSE = 3'h4;
  localparam logic [2:0] EXS_IDX_IRQ_STAT = 3'h5;
  localparam logic [2:0] EXS_IDX_IRQ_MASK = 3'h6;
  // ********************
  // Fields and values
  // ********************
  localparam int EXS_ADDR_LSB = 2;
  localparam int EXS_CODE_W = 16;
  localparam int EXS_NUM_EVT = 2;
  localparam int EXS_EVT_NORMAL = 0;
  localparam int EXS_EVT_FATAL = 1;
  localparam logic [31:0] EXS_RST_WORD = 32'h0000_0000;
  localparam logic [15:0] EXS_RST_CODE = 16'h0000;
  localparam logic [1:0] EXS_RST_EVT = 2'h0;
  localparam logic [31:0] EXS_PC_EVEN_MASK = 32'hffff_fffe;
  // Whole state of the block
  typedef struct packed {
    logic [31:0] npc;
    logic [31:0] npsw;
    logic [31:0] fpc;
    logic [31:0] fpsw;
    logic [15:0] fcode;
    logic [15:0] ncode;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [31:0] rdata;
  } exs_state_s;
endpackage : exs_pkg

// ### src/exs_top.sv
// Purpose: Exception state-save registers of a 32-bit core
// Assumes: Core presents accept strobes with PC, status and code
// Notes: APB slave, zero-wait, single clock
// Operation
// - Normal event saves PC and status, unless a fatal event is accepted in the same cycle
// - One normal pair, later event overwrites
// - Fatal event saves into fatal pair
// - Cause of each accepted event recorded; when both come in one cycle only the fatal code is
// - Fatal code goes to upper half
// - Normal code goes to lower half
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module exs_top
  import exs_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Core event inputs
  input wire logic NORMAL_ACCEPT_I,
  input wire logic FATAL_ACCEPT_I,
  input wire logic [31:0] PROGRAM_COUNTER_I,
  input wire logic [31:0] PROGRAM_STATUS_WORD_I,
  input wire logic [15:0] CAUSE_CODE_I,
  // Saved state to the core
  output logic [31:0] NORMAL_EXC_PC_SAVE_O,
  output logic [31:0] NORMAL_EXC_STATUS_SAVE_O,
  output logic [31:0] FATAL_EXC_PC_SAVE_O,
  output logic [31:0] FATAL_EXC_STATUS_SAVE_O,
  output logic [31:0] EXCEPTION_CAUSE_O,
  // Interrupt
  output logic IRQ_O
);
  // ********************
  // State
  // ********************
  exs_state_s state_q; // Registered state
  exs_state_s state_d; // Next state
  logic wr_acc; // APB write access
  logic rd_acc; // APB read setup
  logic [2:0] idx; // Register index
  logic idx_ok; // Mapped address
  logic [1:0] evt; // Events this cycle

  // Decode of the bus request
  always_comb begin
    idx = PADDR_I[EXS_ADDR_LSB +: 3];
    idx_ok = (PADDR_I[31:EXS_ADDR_LSB + 3] == '0) && (idx <= EXS_IDX_IRQ_MASK);
    wr_acc = PSEL_I && PENABLE_I && PWRITE_I && idx_ok;
    rd_acc = PSEL_I && !PENABLE_I && !PWRITE_I;
    evt = '0;
    evt[EXS_EVT_NORMAL] = NORMAL_ACCEPT_I;
    evt[EXS_EVT_FATAL] = FATAL_ACCEPT_I;
  end

  // ********************
  // Next-state logic
  // ********************
  always_comb begin
    state_d = state_q;
    // Software writes first; events below take priority
    if (wr_acc) begin
      unique case (idx)
        EXS_IDX_NPC: state_d.npc = PWDATA_I & EXS_PC_EVEN_MASK;
        EXS_IDX_NPSW: state_d.npsw = PWDATA_I;
        EXS_IDX_FPC: state_d.fpc = PWDATA_I & EXS_PC_EVEN_MASK;
        EXS_IDX_FPSW: state_d.fpsw = PWDATA_I;
        EXS_IDX_IRQ_STAT: state_d.stat = state_q.stat & ~PWDATA_I[1:0];
        EXS_IDX_IRQ_MASK: state_d.mask = PWDATA_I[1:0];
        default: state_d.stat = state_q.stat; // Cause is read only
      endcase
    end
    // Fatal events own the fatal pair
    if (FATAL_ACCEPT_I) begin
      state_d.fpc = PROGRAM_COUNTER_I;
      state_d.fpsw = PROGRAM_STATUS_WORD_I;
      state_d.fcode = CAUSE_CODE_I;
    end else if (NORMAL_ACCEPT_I) begin
      state_d.npc = PROGRAM_COUNTER_I;
      state_d.npsw = PROGRAM_STATUS_WORD_I;
      state_d.ncode = CAUSE_CODE_I;
    end
    state_d.stat = state_d.stat | evt;
    // Read data captured in setup; unmapped reads return zero
    if (rd_acc && !idx_ok) begin
      state_d.rdata = EXS_RST_WORD;
    end else if (rd_acc) begin
      unique case (idx)
        EXS_IDX_NPC: state_d.rdata = state_q.npc;
        EXS_IDX_NPSW: state_d.rdata = state_q.npsw;
        EXS_IDX_FPC: state_d.rdata = state_q.fpc;
        EXS_IDX_FPSW: state_d.rdata = state_q.fpsw;
        EXS_IDX_CAUSE: state_d.rdata = {state_q.fcode, state_q.ncode};
        EXS_IDX_IRQ_STAT: state_d.rdata = {30'h0, state_q.stat};
        EXS_IDX_IRQ_MASK: state_d.rdata = {30'h0, state_q.mask};
        default: state_d.rdata = EXS_RST_WORD;
      endcase
    end
  end

  // Register the state
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_q <= '{npc: EXS_RST_WORD, npsw: EXS_RST_WORD, fpc: EXS_RST_WORD,
                   fpsw: EXS_RST_WORD, fcode: EXS_RST_CODE, ncode: EXS_RST_CODE,
                   stat: EXS_RST_EVT, mask: EXS_RST_EVT, rdata: EXS_RST_WORD};
    end else begin
      state_q <= state_d;
    end
  end

  // ********************
  // Outputs
  // ********************
  assign PRDATA_O = state_q.rdata;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !idx_ok;
  assign NORMAL_EXC_PC_SAVE_O = state_q.npc;
  assign NORMAL_EXC_STATUS_SAVE_O = state_q.npsw;
  assign FATAL_EXC_PC_SAVE_O = state_q.fpc;
  assign FATAL_EXC_STATUS_SAVE_O = state_q.fpsw;
  assign EXCEPTION_CAUSE_O = {state_q.fcode, state_q.ncode};
  assign IRQ_O = |(state_q.stat & state_q.mask);
endmodule : exs_top
`default_nettype wire

// ### verification/exs_sva.sv
// Purpose: Checks on exception state capture
// Assumes: Bound into exs_top
// Notes: One clock domain
`timescale 1ns/10ps
`default_nettype none
module exs_sva (
  // Event side
  input wire logic CLK_I, RST_I, PSEL_I, PENABLE_I, PWRITE_I, NORMAL_ACCEPT_I, FATAL_ACCEPT_I,
  input wire logic [31:0] PROGRAM_COUNTER_I, PROGRAM_STATUS_WORD_I,
  input wire logic [15:0] CAUSE_CODE_I,
  // Saved state
  input wire logic [31:0] NORMAL_EXC_PC_SAVE_O, NORMAL_EXC_STATUS_SAVE_O, FATAL_EXC_PC_SAVE_O,
  input wire logic [31:0] FATAL_EXC_STATUS_SAVE_O, EXCEPTION_CAUSE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // Normal-only event, software write
  wire logic n_only = NORMAL_ACCEPT_I && !FATAL_ACCEPT_I;
  wire logic wr = PSEL_I && PENABLE_I && PWRITE_I;
  chk_normal_pair:
  assert property (n_only |=> NORMAL_EXC_PC_SAVE_O == $past(PROGRAM_COUNTER_I)
    && NORMAL_EXC_STATUS_SAVE_O == $past(PROGRAM_STATUS_WORD_I)) else $error("normal pair");
  chk_normal_held:
  assert property (!NORMAL_ACCEPT_I && !wr |=> $stable(NORMAL_EXC_PC_SAVE_O)) else $error("npc");
  chk_fatal_pair:
  assert property (FATAL_ACCEPT_I |=> FATAL_EXC_PC_SAVE_O == $past(PROGRAM_COUNTER_I)
    && FATAL_EXC_STATUS_SAVE_O == $past(PROGRAM_STATUS_WORD_I)) else $error("fatal pair");
  chk_normal_untouched:
  assert property (FATAL_ACCEPT_I && !wr |=> $stable(NORMAL_EXC_STATUS_SAVE_O)) else $error("npsw");
  chk_cause_idle:
  assert property (!NORMAL_ACCEPT_I && !FATAL_ACCEPT_I |=> $stable(EXCEPTION_CAUSE_O)) else $error("c");
  chk_fatal_code:
  assert property (FATAL_ACCEPT_I |=> EXCEPTION_CAUSE_O[31:16] == $past(CAUSE_CODE_I)) else $error("f");
  chk_normal_code:
  assert property (n_only |=> EXCEPTION_CAUSE_O[15:0] == $past(CAUSE_CODE_I)) else $error("n");
  chk_upper_kept:
  assert property (n_only |=> $stable(EXCEPTION_CAUSE_O[31:16])) else $error("upper half");
endmodule : exs_sva
bind exs_top exs_sva chk_i (.*);
`default_nettype wire

// ### verification/testbench.sv
// Purpose: Self-checking bench for exs_top
// Assumes: Zero-wait APB slave
// Notes: Rows hold event inputs and expected cause
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import exs_pkg::*;
  typedef struct {logic n, f; logic [31:0] pc, program_status_word, cause; logic [15:0] code;} exs_row_s;
  logic clk = 0, rst = 1, sel = 0, en = 0, wr = 0, na = 0, fa = 0, rdy, err, irq, e;
  logic [31:0] addr = 0, wd = 0, pc = 0, program_status_word = 0, rd, cause, r;
  logic [15:0] code = 0;
  logic [31:0] o [4];
  logic [31:0] x [4] = '{default: 32'h0};
  int fail_count = 0, comparisons = 0;
  exs_row_s rows [3] = '{'{1, 0, 32'h100, 32'h11, 32'h10, 16'h10},
    '{1, 0, 32'h204, 32'h22, 32'h20, 16'h20}, '{0, 1, 32'h308, 32'h33, 32'hc0_0020, 16'hc0}};
  exs_top dut (.CLK_I(clk), .RST_I(rst), .PSEL_I(sel), .PENABLE_I(en), .PWRITE_I(wr),
    .PADDR_I(addr), .PWDATA_I(wd), .PRDATA_O(rd), .PREADY_O(rdy), .PSLVERR_O(err),
    .NORMAL_ACCEPT_I(na), .FATAL_ACCEPT_I(fa), .PROGRAM_COUNTER_I(pc),
    .PROGRAM_STATUS_WORD_I(program_status_word), .CAUSE_CODE_I(code), .NORMAL_EXC_PC_SAVE_O(o[0]),
    .NORMAL_EXC_STATUS_SAVE_O(o[1]), .FATAL_EXC_PC_SAVE_O(o[2]),
    .FATAL_EXC_STATUS_SAVE_O(o[3]), .EXCEPTION_CAUSE_O(cause), .IRQ_O(irq));
  initial forever #5 clk = ~clk;
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One APB transfer, held until ready
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge clk) {sel, en, wr, addr, wd} <= {2'h2, w, a, d};
    @(posedge clk) en <= 1'h1;
    do @(posedge clk); while (rdy !== 1'h1);
    {r, e} = {rd, err};
    {sel, en} <= 2'h0;
    #1;
  endtask : apb
  // Verdict
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  initial begin
    #20000 fail_count++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    #1 chk("cause", cause, 32'h0);
    foreach (rows[i]) begin
      @(posedge clk) {na, fa, pc, program_status_word, code} <= {rows[i].n, rows[i].f, rows[i].pc, rows[i].program_status_word,
        rows[i].code};
      @(posedge clk) {na, fa} <= 2'h0;
      #1 if (rows[i].n) {x[0], x[1]} = {rows[i].pc, rows[i].program_status_word};
      if (rows[i].f) {x[2], x[3]} = {rows[i].pc, rows[i].program_status_word};
      for (int k = 0; k < 4; k++) chk("save", o[k], x[k]);
      chk("cause", cause, rows[i].cause);
    end
    // Both classes in one cycle: fatal pair and upper code only
    @(posedge clk) {na, fa, pc, program_status_word, code} <= {2'h3, 32'h40c, 32'h44, 16'hd0};
    @(posedge clk) {na, fa} <= 2'h0;
    #1 chk("fatal pc", o[2], 32'h40c);
    chk("normal pc", o[0], x[0]);
    chk("both cause", cause, 32'hd0_0020);
    apb(1, 32'h0, 32'h1235);
    apb(0, 32'h0, 32'h0);
    chk("pc read", r, 32'h1234);
    apb(1, 32'h10, 32'hffff_ffff);
    apb(0, 32'h10, 32'h0);
    chk("cause read", r, 32'hd0_0020);
    apb(0, 32'h1c, 32'h0);
    chk("error", e, 1'h1);
    apb(0, 32'h20, 32'h0);
    chk("high error", e, 1'h1);
    chk("high read", r, 32'h0);
    chk("irq", irq, 1'h0);
    apb(1, 32'h18, 32'h1);
    chk("irq", irq, 1'h1);
    apb(1, 32'h14, 32'h1);
    chk("irq", irq, 1'h0);
    apb(0, 32'h14, 32'h0);
    chk("status", r, 32'h2);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
